// ### design/cc_timer_map.vh
`ifndef CC_TIMER_MAP_VH
`define CC_TIMER_MAP_VH
// ---------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_COUNT 8'h04
`define OFS_PERSH 8'h08
`define OFS_CCTL_BASE 8'h10
`define OFS_CCR_BASE 8'h14
`define OFS_CH_STRIDE 8'h08
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTRL_WRAP 0
`define CTRL_CLEAR 2
`define CTRL_MODE_LO 4
`define CTRL_DIV_LO 6
`define CTRL_SRC_LO 8
// ---------------------------------------------------------------
// channel control register fields
// ---------------------------------------------------------------
`define CC_EVENT 0
`define CC_OVR 1
`define CC_OUTBIT 2
`define CC_LEVEL 3
`define CC_OUTMODE_LO 5
`define CC_CAPSEL 8
`define CC_LATCHED 10
`define CC_SYNC 11
`define CC_INSEL_LO 12
`define CC_EDGE_LO 14
// ---------------------------------------------------------------
// encodings
// ---------------------------------------------------------------
`define MODE_STOP 2'h0
`define MODE_UP 2'h1
`define MODE_CONT 2'h2
`define MODE_UPDN 2'h3
`define SRC_CLK 2'h0
`define SRC_TICK_A 2'h1
`define SRC_TICK_B 2'h2
`define SRC_TICK_A_FALL 2'h3
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define IN_A 2'h0
`define IN_B 2'h1
`define IN_GND 2'h2
`define IN_VCC 2'h3
`define OM_OUTBIT 3'h0
`define OM_SET 3'h1
`define OM_TOG_RST 3'h2
`define OM_SET_RST 3'h3
`define OM_TOGGLE 3'h4
`define OM_RESET 3'h5
`define OM_TOG_SET 3'h6
`define OM_RST_SET 3'h7
`define DIV_1 2'h0
`define DIV_2 2'h1
`define DIV_4 2'h2
// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define NUM_CH 3
`define CNT_MAX 16'hffff
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define DIR_UP 1'b0
`define DIR_DOWN 1'b1
`define RST16 16'h0000
`define RST3 3'h0
`define RST32 32'h00000000
`define LAST_DIV_1 3'h0
`define LAST_DIV_2 3'h1
`define LAST_DIV_4 3'h3
`define LAST_DIV_8 3'h7
`endif

// ### design/capture_compare_timer.v
// How it works
// - continuous mode counts to ffff, wraps zero
// - wrap flag set on ffff-to-zero count
// - channel 0 match acts as period match in continuous mode too
// - up/down counts zero to period and back
// - direction kept when stopped; clear resets count, direction, divider
// - up/down: ch0 flag at period, wrap at 1-to-0
// - period write while descending applies after zero
// - larger new period: climb to it first
// - period below count: reverse, one extra allowed
// - channel registers unbuffered, writes act immediately
// - capture select bit picks capture or compare
// - input select: source a, b, gnd, vcc
// - selected edge copies count, sets event flag
// - toggling low select bit triggers software capture
// - sync bit aligns capture to timer tick
// - second unread capture sets overrun, software clears
// - compare match: flag, match, latch input level
// - outputs change on tick, mode 0 follows bit
// - mode 1 sets and holds, mode 5 resets
// - mode 4 toggles each channel match
// - modes 2,3,6,7 act on channel and period match
// - mode field: stop, up, continuous, up/down
// - selectable source, divide by 1,2,4,8
// - software count writes trigger no actions
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`include "cc_timer_map.vh"
module capture_compare_timer (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // bus strobe
  input wire wb_we_i, // write enable
  input wire [7:0] wb_adr_i, // byte address
  input wire [31:0] wb_dat_i, // write data
  input wire [3:0] wb_sel_i, // byte lanes
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  input wire tick_a, // external count source a
  input wire tick_b, // external count source b
  input wire [2:0] capture_source_a, // capture input a per channel
  input wire [2:0] capture_source_b, // capture input b per channel
  output reg [2:0] channel_output, // output unit pins
  output reg [2:0] channel_match // one-cycle compare match
);

  // -------------------------------------------------------------
  // shared helpers
  // -------------------------------------------------------------
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] sel;
    begin
      merge16 = old;
      if (sel[0]) merge16[7:0] = wd[7:0];
      if (sel[1]) merge16[15:8] = wd[15:8];
    end
  endfunction

  // -------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire wr_ctrl = wr & (wb_adr_i == `OFS_CTRL);
  wire wr_cnt = wr & (wb_adr_i == `OFS_COUNT);
  wire clr = wr_ctrl & wb_sel_i[0] & wb_dat_i[`CTRL_CLEAR];

  reg [15:0] count_value_q, count_value_d;
  reg dir_q, dir_d;
  reg [15:0] period_shadow_q, period_shadow_d;
  reg [1:0] count_mode_field_q, clock_divide_field_q, src_q;
  reg counter_wrap_flag_q;
  reg [2:0] div_cnt_q;
  reg tick_a_q, tick_b_q;
  reg wrap_set, counted;
  reg [31:0] rdata;

  wire [16*`NUM_CH-1:0] ccr_all;
  wire [16*`NUM_CH-1:0] cctl_all;
  wire [15:0] period_compare_reg = ccr_all[15:0];

  // -------------------------------------------------------------
  // clock source and divider
  // -------------------------------------------------------------
  reg src_tick;
  reg [2:0] div_last;
  always @* begin
    case (src_q)
      `SRC_CLK: src_tick = 1'b1;
      `SRC_TICK_A: src_tick = tick_a & ~tick_a_q;
      `SRC_TICK_B: src_tick = tick_b & ~tick_b_q;
      `SRC_TICK_A_FALL: src_tick = ~tick_a & tick_a_q;
      default: src_tick = 1'b0;
    endcase
    case (clock_divide_field_q)
      `DIV_1: div_last = `LAST_DIV_1;
      `DIV_2: div_last = `LAST_DIV_2;
      `DIV_4: div_last = `LAST_DIV_4;
      default: div_last = `LAST_DIV_8;
    endcase
  end
  // a source edge on the divider's last step is one timer clock
  wire tick = src_tick & (div_cnt_q == div_last) & ~clr;

  always @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_q <= `RST3;
      tick_a_q <= 1'b0;
      tick_b_q <= 1'b0;
    end else begin
      tick_a_q <= tick_a;
      tick_b_q <= tick_b;
      if (clr)
        div_cnt_q <= `RST3;
      else if (src_tick)
        div_cnt_q <= (div_cnt_q == div_last) ? `RST3 :
                     div_cnt_q + 3'h1;
    end
  end

  // -------------------------------------------------------------
  // counter
  // -------------------------------------------------------------
  always @* begin
    count_value_d = count_value_q;
    dir_d = dir_q;
    period_shadow_d = period_shadow_q;
    wrap_set = 1'b0;
    counted = 1'b0;
    // descending keeps the old turn point until zero
    if (dir_q == `DIR_UP)
      period_shadow_d = period_compare_reg;
    if (clr) begin
      count_value_d = `CNT_ZERO;
      dir_d = `DIR_UP;
    end else if (wr_cnt) begin
      count_value_d = merge16(count_value_q, wb_dat_i, wb_sel_i);
    end else if (tick) begin
      case (count_mode_field_q)
        `MODE_CONT: begin
          count_value_d = count_value_q + `CNT_ONE;
          counted = 1'b1;
          wrap_set = (count_value_q == `CNT_MAX);
        end
        `MODE_UP: begin
          counted = 1'b1;
          if (count_value_q >= period_compare_reg) begin
            count_value_d = `CNT_ZERO;
            wrap_set = 1'b1;
          end else
            count_value_d = count_value_q + `CNT_ONE;
        end
        `MODE_UPDN: begin
          if (dir_q == `DIR_UP) begin
            // zero period leaves the counter parked at its current count
            if (period_shadow_q != `CNT_ZERO) begin
              counted = 1'b1;
              if (count_value_q >= period_shadow_q) begin
                dir_d = `DIR_DOWN;
                count_value_d = count_value_q - `CNT_ONE;
              end else
                count_value_d = count_value_q + `CNT_ONE;
            end
          end else begin
            counted = 1'b1;
            if (count_value_q <= `CNT_ONE) begin
              count_value_d = `CNT_ZERO;
              dir_d = `DIR_UP;
              wrap_set = (count_value_q == `CNT_ONE);
              period_shadow_d = period_compare_reg;
            end else
              count_value_d = count_value_q - `CNT_ONE;
          end
        end
        default: ; // stopped: direction held
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      count_value_q <= `RST16;
      dir_q <= `DIR_UP;
      period_shadow_q <= `RST16;
      count_mode_field_q <= `MODE_STOP;
      clock_divide_field_q <= `DIV_1;
      src_q <= `SRC_CLK;
      counter_wrap_flag_q <= 1'b0;
    end else begin
      count_value_q <= count_value_d;
      dir_q <= dir_d;
      period_shadow_q <= period_shadow_d;
      if (wr_ctrl & wb_sel_i[0]) begin
        count_mode_field_q <= wb_dat_i[`CTRL_MODE_LO+:2];
        clock_divide_field_q <= wb_dat_i[`CTRL_DIV_LO+:2];
      end
      if (wr_ctrl & wb_sel_i[1])
        src_q <= wb_dat_i[`CTRL_SRC_LO+:2];
      // hardware set beats a software clear in the same cycle
      if (wrap_set)
        counter_wrap_flag_q <= 1'b1;
      else if (wr_ctrl & wb_sel_i[0])
        counter_wrap_flag_q <= wb_dat_i[`CTRL_WRAP];
    end
  end

  // period match is channel 0's match
  wire period_match = counted & (count_value_d == period_compare_reg);

  // -------------------------------------------------------------
  // capture/compare channels
  // -------------------------------------------------------------
  wire [2:0] out_d;
  wire [2:0] match_d;
  genvar i;
  generate
    for (i = 0; i < `NUM_CH; i = i + 1) begin : gen_ch
      localparam integer CTL_OFS = `OFS_CCTL_BASE + `OFS_CH_STRIDE * i;
      localparam integer CCR_OFS = `OFS_CCR_BASE + `OFS_CH_STRIDE * i;
      localparam [7:0] CTL_ADR = CTL_OFS[7:0];
      localparam [7:0] CCR_ADR = CCR_OFS[7:0];
      reg [15:0] channel_compare_reg_q;
      reg [1:0] edge_q, insel_q;
      reg sync_q, capsel_q, outbit_q, latched_q;
      reg [2:0] output_mode_field_q;
      reg event_q, ovr_q, unread_q, prev_q, pend_q, out_q;
      reg lvl, edge_hit, out_n;
      wire wr_ctl = wr & (wb_adr_i == CTL_ADR);
      wire wr_ccr = wr & (wb_adr_i == CCR_ADR);
      wire rd_ccr = rd & (wb_adr_i == CCR_ADR);

      always @* begin
        case (insel_q)
          `IN_A: lvl = capture_source_a[i];
          `IN_B: lvl = capture_source_b[i];
          `IN_GND: lvl = 1'b0;
          default: lvl = 1'b1;
        endcase
        // edges on the selected level, so a select toggle counts too
        case (edge_q)
          `EDGE_RISE: edge_hit = lvl & ~prev_q;
          `EDGE_FALL: edge_hit = ~lvl & prev_q;
          `EDGE_BOTH: edge_hit = lvl ^ prev_q;
          default: edge_hit = 1'b0;
        endcase
      end

      wire cap_arm = capsel_q & (edge_hit | pend_q);
      wire cap_now = cap_arm & (~sync_q | tick);
      wire cmp_hit = ~capsel_q & counted &
                     (count_value_d == channel_compare_reg_q);
      // channel 0 match acts as period match in every counting mode
      wire ev_set = cap_now | cmp_hit;

      always @* begin
        out_n = out_q;
        case (output_mode_field_q)
          `OM_OUTBIT: out_n = outbit_q;
          `OM_SET: if (cmp_hit) out_n = 1'b1;
          `OM_RESET: if (cmp_hit) out_n = 1'b0;
          `OM_TOGGLE: if (cmp_hit) out_n = ~out_q;
          `OM_TOG_RST, `OM_TOG_SET: if (cmp_hit) out_n = ~out_q;
          `OM_SET_RST: if (cmp_hit) out_n = 1'b1;
          default: if (cmp_hit) out_n = 1'b0;
        endcase
        if (period_match & ~capsel_q) begin
          if (output_mode_field_q == `OM_TOG_RST ||
              output_mode_field_q == `OM_SET_RST)
            out_n = 1'b0;
          else if (output_mode_field_q == `OM_TOG_SET ||
                   output_mode_field_q == `OM_RST_SET)
            out_n = 1'b1;
        end
      end
      assign out_d[i] = out_n;
      assign match_d[i] = cmp_hit;

      always @(posedge clk) begin
        if (!rst_n) begin
          channel_compare_reg_q <= `RST16;
          edge_q <= `EDGE_NONE;
          insel_q <= `IN_A;
          sync_q <= 1'b0;
          capsel_q <= 1'b0;
          outbit_q <= 1'b0;
          latched_q <= 1'b0;
          output_mode_field_q <= `OM_OUTBIT;
          event_q <= 1'b0;
          ovr_q <= 1'b0;
          unread_q <= 1'b0;
          prev_q <= 1'b0;
          pend_q <= 1'b0;
          out_q <= 1'b0;
        end else begin
          prev_q <= lvl;
          out_q <= out_n;
          pend_q <= cap_arm & ~cap_now;
          if (cap_now)
            channel_compare_reg_q <= count_value_q;
          else if (wr_ccr)
            channel_compare_reg_q <= merge16(channel_compare_reg_q,
                                             wb_dat_i, wb_sel_i);
          if (cmp_hit)
            latched_q <= lvl;
          if (wr_ctl & wb_sel_i[0]) begin
            outbit_q <= wb_dat_i[`CC_OUTBIT];
            output_mode_field_q <= wb_dat_i[`CC_OUTMODE_LO+:3];
          end
          if (wr_ctl & wb_sel_i[1]) begin
            capsel_q <= wb_dat_i[`CC_CAPSEL];
            sync_q <= wb_dat_i[`CC_SYNC];
            insel_q <= wb_dat_i[`CC_INSEL_LO+:2];
            edge_q <= wb_dat_i[`CC_EDGE_LO+:2];
          end
          if (ev_set)
            event_q <= 1'b1;
          else if (wr_ctl & wb_sel_i[0])
            event_q <= wb_dat_i[`CC_EVENT];
          if (cap_now & unread_q)
            ovr_q <= 1'b1;
          else if (wr_ctl & wb_sel_i[0])
            ovr_q <= wb_dat_i[`CC_OVR];
          // a capture in the read cycle leaves the new value unread
          if (cap_now)
            unread_q <= 1'b1;
          else if (rd_ccr)
            unread_q <= 1'b0;
        end
      end

      assign ccr_all[16*i+:16] = channel_compare_reg_q;
      assign cctl_all[16*i+:16] = {edge_q, insel_q, sync_q, latched_q,
                                   1'b0, capsel_q, output_mode_field_q,
                                   1'b0, lvl, outbit_q, ovr_q, event_q};
    end
  endgenerate

  // -------------------------------------------------------------
  // read mux and outputs
  // -------------------------------------------------------------
  integer k;
  always @* begin
    rdata = `RST32;
    if (wb_adr_i == `OFS_CTRL)
      rdata[15:0] = {6'h00, src_q, clock_divide_field_q,
                     count_mode_field_q, 3'h0, counter_wrap_flag_q};
    else if (wb_adr_i == `OFS_COUNT)
      rdata[15:0] = count_value_q;
    else if (wb_adr_i == `OFS_PERSH)
      rdata[15:0] = period_shadow_q;
    for (k = 0; k < `NUM_CH; k = k + 1) begin
      if (wb_adr_i == `OFS_CCTL_BASE + `OFS_CH_STRIDE * k[7:0])
        rdata[15:0] = cctl_all[16*k+:16];
      if (wb_adr_i == `OFS_CCR_BASE + `OFS_CH_STRIDE * k[7:0])
        rdata[15:0] = ccr_all[16*k+:16];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `RST32;
      channel_output <= `RST3;
      channel_match <= `RST3;
    end else begin
      wb_ack_o <= req;
      if (rd)
        wb_dat_o <= rdata;
      channel_output <= out_d;
      channel_match <= match_d;
    end
  end

endmodule // capture_compare_timer

// ### tb/cc_pins_model.sv
// ------------------------------------------------------------
// far side: capture inputs and count sources
// ------------------------------------------------------------
module cc_pins_model (
  input wire clk, // system clock
  input wire rst_n, // reset, active low
  input wire [2:0] drive_a, // requested levels on inputs a
  output logic [2:0] capture_source_a, // capture inputs a
  output logic [2:0] capture_source_b, // capture inputs b
  output logic tick_a, // count source a
  output logic tick_b // count source b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q;
  // b lines get a new random level every clock, so a stale level cannot pass for a capture
  always @(posedge clk) begin
    if (!rst_n) begin
      capture_source_a <= 3'h0;
      capture_source_b <= 3'h0;
      div_q <= 2'h0;
      tick_a <= 1'b0;
      tick_b <= 1'b0;
    end else begin
      capture_source_a <= drive_a;
      capture_source_b <= 3'($urandom);
      div_q <= div_q + 2'h1;
      tick_a <= div_q[1];
      tick_b <= ~div_q[1];
    end
  end
endmodule // cc_pins_model

// ### tb/cc_timer_monitor.sv
// ------------------------------------------------------------
// bus handshake and pin checks
// ------------------------------------------------------------
module cc_timer_monitor (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // bus strobe
  input wire wb_we_i, // write enable
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // acknowledge
  input wire [2:0] channel_output, // output unit pins
  input wire [2:0] channel_match // compare match pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  req_ack_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  idle_no_ack_a: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack after idle cycle");
  read_upper_a: assert property (wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  read_hold_a: assert property (
    !$stable(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  match_pulse_a: assert property (
    (channel_match & $past(channel_match)) == 3'h0)
    else $error("match pulse longer than one cycle");
  reset_quiet_a: assert property ($rose(rst_n) |->
    !wb_ack_o && channel_match == 3'h0 && channel_output == 3'h0)
    else $error("outputs not cleared by reset");
endmodule // cc_timer_monitor
bind capture_compare_timer cc_timer_monitor i_mon (
  .clk(clk),
  .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .channel_output(channel_output),
  .channel_match(channel_match)
);

// ### tb/capture_compare_timer_tb_top.sv
`include "cc_timer_map.vh"
module capture_compare_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] cc1 = `OFS_CCTL_BASE + `OFS_CH_STRIDE;
  localparam logic [7:0] cc2 = `OFS_CCTL_BASE + 8'h10;
  localparam logic [7:0] mid_out = 8'hd2;
  localparam logic [7:0] fin_out = 8'h0e;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] sel = 4'hf;
  logic ack;
  logic [2:0] drive_a = 3'h0, src_a, src_b, pin_out, match;
  logic tick_a, tick_b;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int error_cnt = 0, n_tests = 0, p, d, s, t;
  capture_compare_timer i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .tick_a(tick_a),
    .tick_b(tick_b), .capture_source_a(src_a), .capture_source_b(src_b),
    .channel_output(pin_out), .channel_match(match));
  cc_pins_model i_pins (.clk(clk), .rst_n(rst_n), .drive_a(drive_a),
    .capture_source_a(src_a), .capture_source_b(src_b), .tick_a(tick_a),
    .tick_b(tick_b));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, s);
    n_tests++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  // reads leave their expectation, compared when the ack shows up
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] dt, m);
    int k;
    if (!w)
      exp_q.push_back({m, dt});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      give_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_m(input int i, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (match[i] !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e = exp_q.pop_front();
      chk("read data", e[31:0] & e[63:32], rdat & e[63:32]);
    end
  end
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(76314));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(0, `OFS_CTRL, 32'h0, '1);
    wb(0, 8'hfc, 32'h0, '1);
    wb(0, `OFS_CCTL_BASE, 32'h0, '1);
    wb(1, `OFS_COUNT, 32'hfff0, 0);
    wb(0, `OFS_COUNT, 32'hfff0, '1);
    wb(0, `OFS_CTRL, 32'h0, '1);
    wb(1, `OFS_CCR_BASE, 32'h8, 0);
    wb(1, `OFS_CCR_BASE + `OFS_CH_STRIDE, 32'hc, 0);
    wb(1, `OFS_CCTL_BASE, 32'h20, 0);
    wb(1, cc1, 32'h80, 0);
    wb(1, `OFS_CTRL, 32'h20, 0);
    wait_m(0, t);
    wait_m(1, t);
    chk("ch1 after ch0", 32'd4, 32'(t));
    repeat (2) @(posedge clk);
    chk("cont outputs", 32'h3, {29'h0, pin_out});
    wb(0, `OFS_CTRL, 32'h21, '1);
    wb(0, `OFS_COUNT, 32'h0, 32'hffffff00);
    for (int i = 0; i < 3; i++) begin
      p = $urandom_range(20, 3);
      d = $urandom_range(3, 0);
      s = $urandom_range(3, 0);
      wb(1, `OFS_CTRL, 32'h0, 0);
      wb(1, `OFS_CCR_BASE, 32'(p), 0);
      wb(1, `OFS_CTRL, 32'(32'h34 | (d << 6) | (s << 8)), 0);
      wait_m(0, t);
      wait_m(0, t);
      // model sources give one edge every four clocks
      d = ((2 * p) << d) * (s > 0 ? 4 : 1);
      chk("updown period", 32'(d), 32'(t));
      wb(0, `OFS_CTRL, 32'h1, 32'h1);
    end
    wb(1, `OFS_CCR_BASE, 32'h8, 0);
    wb(1, `OFS_CCR_BASE + `OFS_CH_STRIDE, 32'h2, 0);
    wb(1, `OFS_CTRL, 32'h34, 0);
    wait_m(0, t);
    wb(1, `OFS_CTRL, 32'h0, 0);
    wb(1, `OFS_COUNT, 32'h4, 0);
    wb(1, `OFS_CTRL, 32'h30, 0);
    wait_m(1, t);
    // going up again would need ten ticks to reach two
    chk("resume down", 32'h1, {31'h0, t < 4});
    wb(1, `OFS_CCR_BASE + `OFS_CH_STRIDE, 32'h3, 0);
    wb(1, cc1, 32'h4, 0);
    repeat (2) @(posedge clk);
    chk("mode0 out", 32'h1, {31'h0, pin_out[1]});
    for (int m = 1; m < 8; m++) begin
      wb(1, `OFS_CTRL, 32'h0, 0);
      wb(1, cc1, 32'h0, 0);
      wb(1, cc1, 32'(m << 5), 0);
      wb(1, `OFS_CTRL, 32'h34, 0);
      wait_m(0, t);
      repeat (2) @(posedge clk);
      chk("mid out", {31'h0, mid_out[m]}, {31'h0, pin_out[1]});
      wait_m(1, t);
      repeat (2) @(posedge clk);
      chk("end out", {31'h0, fin_out[m]}, {31'h0, pin_out[1]});
    end
    wb(1, cc2, 32'h4100, 0);
    drive_a <= 3'h4;
    repeat (4) @(posedge clk);
    wb(0, cc2, 32'h4109, '1);
    drive_a <= 3'h0;
    repeat (4) @(posedge clk);
    drive_a <= 3'h4;
    repeat (4) @(posedge clk);
    wb(0, cc2, 32'h410b, '1);
    wb(0, cc2 + 8'h04, 32'h0, 32'hfffffff0);
    drive_a <= 3'h0;
    repeat (4) @(posedge clk);
    wb(1, cc2, 32'he900, 0);
    wb(1, cc2, 32'hf900, 0);
    repeat (4) @(posedge clk);
    wb(0, cc2, 32'hf909, '1);
    give_verdict();
  end
endmodule // capture_compare_timer_tb_top
